//--- nbu_chk.sv
// Purpose: Port assertions for the nine-bit serial port engine
// Assumes: One clock domain, active-low asynchronous reset
// Notes: Bound to nbu_uart from the bench
`timescale 1ns/1ps
module nbu_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Controls
  input wire logic txDoneClr,
  input wire logic rxFullClr,
  input wire logic ctrlBit7Wr,
  input wire logic frameErrSelect,
  input wire logic modeSelHigh,
  input wire logic multiprocEnable,
  // Results
  input wire logic [7:0] rxBufData,
  input wire logic rxNinthBit,
  input wire logic rxFullFlag,
  input wire logic txDoneFlag,
  input wire logic frameErrFlag,
  input wire logic serialIrq,
  input wire logic txd
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  irq_or_a:
    assert property (serialIrq == (txDoneFlag | rxFullFlag)) else $error("irq not flag OR");
  done_hold_a:
    assert property (txDoneFlag && !txDoneClr |=> txDoneFlag) else $error("done flag lost");
  full_hold_a:
    assert property (rxFullFlag && !rxFullClr |=> rxFullFlag) else $error("full flag lost");
  ferr_hold_a:
    assert property (frameErrFlag && !ctrlBit7Wr |=> frameErrFlag) else $error("frame error lost");
  buf_locked_a:
    assert property (rxFullFlag |=> $stable(rxBufData) && $stable(rxNinthBit))
      else $error("buffer changed while full");
  bit_hold_a:
    assert property ($changed(txd) |=> $stable(txd)[*8]) else $error("line bit too short");
  done_stop_a:
    assert property ($rose(txDoneFlag) |-> txd) else $error("done flag off stop bit");
  ferr_select_a:
    assert property ($rose(frameErrFlag) |-> frameErrSelect) else $error("frame error unselected");
  addr_ninth_a:
    assert property ($rose(rxFullFlag) && modeSelHigh && multiprocEnable |-> rxNinthBit)
      else $error("data byte passed filter");
  cover property ($rose(txDoneFlag));
  cover property ($rose(rxFullFlag));
  cover property ($rose(frameErrFlag));
endmodule : nbu_chk

//--- nbu_pkg.sv
// Purpose: Shared constants and types for the nine-bit serial port engine
// Assumes: One 20 MHz clock, active-low asynchronous reset
// Notes: Mode encoding is {mode_sel_high, mode_sel_low}
// How it works
// RULE1: Mode high=1, low=0 selects nine-bit UART at fixed clock-derived rate.
// RULE2: Nine-bit frame is start low, eight data, ninth bit, stop high.
// RULE3: Transmit ninth bit from txNinthBit; received ninth bit stored in rxNinthBit.
// RULE4: Fixed mode bit rate is clock/64, or clock/32 with rateDouble set.
// RULE5: Buffer write loads ninth bit, requests send; start waits for next rollover.
// RULE6: Start bit first, data path one bit later, first shift after another.
// RULE7: Stop bit shifted in behind ninth bit; done flag at eleventh rollover.
// RULE8: Receive line sampled sixteen per bit; falling edge resets counter, loads 1FF.
// RULE9: Samples at counter states 7, 8, 9; two of three decide the bit.
// RULE10: Start bit accepted as 1 aborts reception and resumes edge search.
// RULE11: Final shift loads buffer, ninth bit, flag if flag clear and qualified.
// RULE12: Unqualified frame is dropped silently; receiver always returns to edge search.
// RULE13: Stop bit value never touches buffer, ninth bit or flag in nine-bit modes.
// RULE14: Variable nine-bit mode equals fixed mode except rate comes from timers.
// RULE15: Buffer write starts sending; reception needs receive enable and start edge.
// RULE16: Missing stop sets frame error; control bit 7 shared with mode low. Here frame error is set only while frameErrSelect is 1.
// RULE17: Frame error flag is cleared only by software, never by hardware.
// RULE18: Eight-bit mode with multiprocessor bit needs valid stop to set flag.
// RULE19: Nine-bit multiprocessor reception needs ninth bit 1 and address match.
// RULE20: Eight-bit multiprocessor reception needs valid stop and address match.
// RULE21: Given address is slave address under mask; mask zeros are don't care.
// RULE22: Broadcast address is address OR mask; its zero bits are don't care.
// RULE23: Reset clears slave address and mask, so every address matches.
// RULE24: Address compare uses the eight data bits only.
// RULE25: Done and receive flags stay until software clears; interrupt while either set.
package nbu_pkg;
  // Divide-by-16 counter and majority sample points
  localparam logic [3:0] DIV16_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_SECOND = 4'h8;
  localparam logic [3:0] SAMPLE_THIRD = 4'h9;
  // Frame lengths in bit times
  localparam logic [3:0] FRAME_BITS_NINE = 4'hB;
  localparam logic [3:0] FRAME_BITS_EIGHT = 4'hA;
  // Oversample tick dividers, stored as terminal count (divide minus one)
  localparam logic [1:0] FIXED_DIV_NORM = 2'h3;
  localparam logic [1:0] FIXED_DIV_DOUBLE = 2'h1;
  localparam logic [1:0] T1_DIV_NORM = 2'h1;
  localparam logic [1:0] T1_DIV_DOUBLE = 2'h0;
  localparam logic [1:0] T2_DIV = 2'h0;
  // Receive shift register load value
  localparam logic [8:0] RX_LOAD = 9'h1FF;
  // Mode encodings
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_VAR8 = 2'h1;
  localparam logic [1:0] MODE_FIX9 = 2'h2;
  localparam logic [1:0] MODE_VAR9 = 2'h3;
  // Reset values
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Transmit word carried through the buffer: {ninth, data}
  localparam int WORD_W = 9;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_SEND = 2'b11} nbu_tx_state_t;
  typedef enum logic [1:0] {RX_HUNT = 2'b00, RX_RECV = 2'b01} nbu_rx_state_t;
endpackage : nbu_pkg

//--- nbu_remote.sv
// Purpose: Remote serial station driving rxd and decoding txd
// Assumes: Bit length in clocks set by the bench
// Notes: Line is held high whenever no frame or glitch is sent
`timescale 1ns/1ps
module nbu_remote (
  // Clock
  input wire logic clock,
  // Serial lines
  output logic rxd,
  input wire logic txd
);
  int bitLen = 64;
  logic [10:0] frames[$];
  initial rxd = 1'b1;
  // Sends n bits LSB first, start bit in f[0]
  task sendFrame(input logic [10:0] f, input int n, input int len);
    for (int i = 0; i < n; i++) begin
      rxd = f[i];
      repeat (len) @(posedge clock);
      #1;
    end
    rxd = 1'b1;
  endtask : sendFrame
  // Short low pulse, not a start bit
  task glitch(input int len);
    rxd = 1'b0;
    repeat (len) @(posedge clock);
    #1;
    rxd = 1'b1;
  endtask : glitch
  // Samples eleven bits mid-bit after each start edge
  always begin : rxMon
    logic [10:0] f;
    @(negedge txd);
    repeat (bitLen / 2) @(posedge clock);
    for (int i = 0; i < 11; i++) begin
      f[i] = txd;
      if (i < 10) repeat (bitLen) @(posedge clock);
    end
    frames.push_back(f);
  end
endmodule : nbu_remote

//--- nbu_stream_if.sv
// Purpose: Valid/ready word stream between the buffer and its neighbours
// Assumes: Source holds data while valid and not ready
// Notes: One word passes when valid and ready are both high on a clock edge
`timescale 1ns/1ps
interface nbu_stream_if;
  logic valid;
  logic ready;
  logic [nbu_pkg::WORD_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : nbu_stream_if

//--- nbu_two_entry_buf.sv
// Purpose: Two-entry buffer in the transmit word path
// Assumes: Single clock, asynchronous active-low reset
// Notes: Input ready is registered so it can feed a top-level output
`timescale 1ns/1ps
module nbu_two_entry_buf (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Streams
  nbu_stream_if.snk inP,
  nbu_stream_if.src outP
);
  logic [nbu_pkg::WORD_W-1:0] mem_r [0:1];
  logic [nbu_pkg::WORD_W-1:0] mem_nxt [0:1];
  logic wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [1:0] count_r, count_nxt;
  logic inReady_r, inReady_nxt;
  logic push, pop;

  assign inP.ready = inReady_r;
  assign outP.valid = (count_r != 2'h0);
  assign outP.data = mem_r[rdPtr_r];

  always_comb begin
    push = inP.valid && inReady_r;
    pop = outP.valid && outP.ready;
    mem_nxt[0] = mem_r[0];
    mem_nxt[1] = mem_r[1];
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (push) begin
      mem_nxt[wrPtr_r] = inP.data;
      wrPtr_nxt = ~wrPtr_r;
    end
    if (pop) begin
      rdPtr_nxt = ~rdPtr_r;
    end
    case ({push, pop})
      2'b10: count_nxt = count_r + 2'h1;
      2'b01: count_nxt = count_r - 2'h1;
      default: count_nxt = count_r;
    endcase
    inReady_nxt = (count_nxt != 2'h2);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
      inReady_r <= 1'b0;
    end else begin
      mem_r[0] <= mem_nxt[0];
      mem_r[1] <= mem_nxt[1];
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
      inReady_r <= inReady_nxt;
    end
  end
endmodule : nbu_two_entry_buf

//--- nbu_uart.sv
// Purpose: Nine-bit serial port engine with address recognition
// Assumes: Timer overflow pulses come from logic on the same clock
// Notes: Shift mode transfers are not implemented; mode 0 leaves the port idle
`timescale 1ns/1ps
module nbu_uart (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Transmit word write
  input wire logic txWrValid,
  input wire logic [7:0] txWrData,
  output logic txWrReady,
  // Control bits
  input wire logic modeSelHigh,
  input wire logic multiprocEnable,
  input wire logic rxEnable,
  input wire logic txNinthBit,
  input wire logic rateDouble,
  input wire logic frameErrSelect,
  input wire logic useTimer2,
  // Shared control bit 7 access
  input wire logic ctrlBit7Wr,
  input wire logic ctrlBit7WrData,
  output logic ctrlBit7Rd,
  // Flag clears
  input wire logic txDoneClr,
  input wire logic rxFullClr,
  // Address registers
  input wire logic slaveAddrWr,
  input wire logic slaveAddrMaskWr,
  input wire logic [7:0] addrWrData,
  // Baud timer overflows
  input wire logic t1Overflow,
  input wire logic t2Overflow,
  // Receive results and flags
  output logic [7:0] rxBufData,
  output logic rxNinthBit,
  output logic rxFullFlag,
  output logic txDoneFlag,
  output logic frameErrFlag,
  output logic serialIrq,
  // Serial lines
  input wire logic rxd,
  output logic txd
);
  function automatic logic maskedEq(input logic [7:0] val, input logic [7:0] pat,
                                    input logic [7:0] mask);
    maskedEq = ((val & mask) == (pat & mask));
  endfunction : maskedEq

  // Transmit buffer
  nbu_stream_if wrS ();
  nbu_stream_if rdS ();
  assign wrS.valid = txWrValid;
  assign wrS.data = {txNinthBit, txWrData}; // RULE3
  assign txWrReady = wrS.ready;

  nbu_two_entry_buf txBuf (
    .clock(clock),
    .nrst(nrst),
    .inP(wrS),
    .outP(rdS)
  );

  // Control registers
  logic modeSelLow_r, modeSelLow_nxt;
  logic frameErr_r, frameErr_nxt;
  logic [7:0] slaveAddr_r, slaveAddr_nxt;
  logic [7:0] slaveAddrMask_r, slaveAddrMask_nxt;
  logic [1:0] mode;
  logic nineBit;
  logic portOn;

  assign mode = {modeSelHigh, modeSelLow_r};
  assign nineBit = modeSelHigh; // RULE1
  assign portOn = (mode != nbu_pkg::MODE_SHIFT);

  // Oversample tick generation
  logic [1:0] pre_r, pre_nxt;
  logic tickEvent;
  logic [1:0] tickLast;
  logic tick16;

  always_comb begin
    if (mode == nbu_pkg::MODE_FIX9) begin
      tickEvent = 1'b1;
      tickLast = rateDouble ? nbu_pkg::FIXED_DIV_DOUBLE : nbu_pkg::FIXED_DIV_NORM; // RULE4
    end else if (useTimer2) begin
      tickEvent = t2Overflow; // RULE14
      tickLast = nbu_pkg::T2_DIV;
    end else begin
      tickEvent = t1Overflow; // RULE14
      tickLast = rateDouble ? nbu_pkg::T1_DIV_DOUBLE : nbu_pkg::T1_DIV_NORM;
    end
    tick16 = portOn && tickEvent && (pre_r == tickLast);
    pre_nxt = pre_r;
    if (!portOn) begin
      pre_nxt = 2'h0;
    end else if (tickEvent) begin
      pre_nxt = (pre_r == tickLast) ? 2'h0 : pre_r + 2'h1;
    end
  end

  // Transmitter
  nbu_pkg::nbu_tx_state_t txState_r, txState_nxt;
  logic [3:0] txCnt_r, txCnt_nxt;
  logic [3:0] txRoll_r, txRoll_nxt;
  logic [3:0] txLen_r, txLen_nxt;
  logic [10:0] txShift_r, txShift_nxt;
  logic txd_r, txd_nxt;
  logic txDone_r, txDone_nxt;
  logic txRollover;

  assign rdS.ready = (txState_r == nbu_pkg::TX_IDLE) && portOn;

  always_comb begin
    txRollover = tick16 && (txCnt_r == nbu_pkg::DIV16_LAST);
    txCnt_nxt = tick16 ? txCnt_r + 4'h1 : txCnt_r;
    txState_nxt = txState_r;
    txRoll_nxt = txRoll_r;
    txLen_nxt = txLen_r;
    txShift_nxt = txShift_r;
    txd_nxt = txd_r;
    txDone_nxt = txDone_r;
    if (txDoneClr) begin
      txDone_nxt = 1'b0;
    end
    case (txState_r)
      nbu_pkg::TX_IDLE: begin
        txd_nxt = 1'b1;
        if (rdS.valid && rdS.ready) begin
          // Stop, ninth, data, start; eight-bit frames send stop in the ninth place
          txShift_nxt = {1'b1, (nineBit ? rdS.data[8] : 1'b1), rdS.data[7:0], 1'b0}; // RULE3 RULE5
          txLen_nxt = nineBit ? nbu_pkg::FRAME_BITS_NINE : nbu_pkg::FRAME_BITS_EIGHT; // RULE2
          txRoll_nxt = 4'h0;
          txState_nxt = nbu_pkg::TX_WAIT; // RULE15
        end
      end
      nbu_pkg::TX_WAIT: begin
        if (txRollover) begin
          txd_nxt = txShift_r[0]; // RULE5 RULE6
          txShift_nxt = {1'b0, txShift_r[10:1]};
          txRoll_nxt = 4'h1;
          txState_nxt = nbu_pkg::TX_SEND;
        end
      end
      nbu_pkg::TX_SEND: begin
        if (txRollover) begin
          txd_nxt = txShift_r[0]; // RULE6 RULE7
          txShift_nxt = {1'b0, txShift_r[10:1]};
          txRoll_nxt = txRoll_r + 4'h1;
          if (txRoll_r + 4'h1 == txLen_r) begin
            txDone_nxt = 1'b1; // RULE7 RULE25
            txState_nxt = nbu_pkg::TX_IDLE;
          end
        end
      end
      default: txState_nxt = nbu_pkg::TX_IDLE;
    endcase
    if (!portOn) begin
      txState_nxt = nbu_pkg::TX_IDLE;
      txd_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pre_r <= 2'h0;
      txState_r <= nbu_pkg::TX_IDLE;
      txCnt_r <= 4'h0;
      txRoll_r <= 4'h0;
      txLen_r <= nbu_pkg::FRAME_BITS_NINE;
      txShift_r <= '1;
      txd_r <= 1'b1;
      txDone_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      txState_r <= txState_nxt;
      txCnt_r <= txCnt_nxt;
      txRoll_r <= txRoll_nxt;
      txLen_r <= txLen_nxt;
      txShift_r <= txShift_nxt;
      txd_r <= txd_nxt;
      txDone_r <= txDone_nxt;
    end
  end

  // Receive line synchroniser
  logic rxS1_r, rxS2_r, rxS3_r, rxLevel_r, rxLevel_nxt;
  logic rxFall;

  always_comb begin
    rxLevel_nxt = (rxS2_r == rxS3_r) ? rxS3_r : rxLevel_r;
    rxFall = rxLevel_r && !rxLevel_nxt;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxS1_r <= 1'b1;
      rxS2_r <= 1'b1;
      rxS3_r <= 1'b1;
      rxLevel_r <= 1'b1;
    end else begin
      rxS1_r <= rxd;
      rxS2_r <= rxS1_r;
      rxS3_r <= rxS2_r;
      rxLevel_r <= rxLevel_nxt;
    end
  end

  // Receiver
  nbu_pkg::nbu_rx_state_t rxState_r, rxState_nxt;
  logic [3:0] rxCnt_r, rxCnt_nxt;
  logic [10:0] rxShift_r, rxShift_nxt;
  logic sampA_r, sampA_nxt, sampB_r, sampB_nxt;
  logic [7:0] rxBuf_r, rxBuf_nxt;
  logic rxNinth_r, rxNinth_nxt;
  logic rxFull_r, rxFull_nxt;
  logic majority;
  logic [10:0] shifted;
  logic frameDone;
  logic [7:0] gotData;
  logic gotNinth, gotStop;
  logic addrMatch;
  logic qualified;
  logic stopMissing;

  always_comb begin
    majority = (sampA_r & sampB_r) | (sampA_r & rxLevel_r) | (sampB_r & rxLevel_r); // RULE9
    shifted = {majority, rxShift_r[10:1]};
    frameDone = nineBit ? !shifted[0] : !shifted[1]; // RULE11
    gotData = nineBit ? shifted[8:1] : shifted[9:2];
    gotNinth = shifted[9];
    gotStop = shifted[10];
    addrMatch = maskedEq(gotData, slaveAddr_r, slaveAddrMask_r) // RULE21 RULE24
      || maskedEq(gotData, slaveAddr_r | slaveAddrMask_r, slaveAddr_r | slaveAddrMask_r); // RULE22
    if (nineBit) begin
      qualified = !multiprocEnable || (gotNinth && addrMatch); // RULE11 RULE13 RULE19
    end else begin
      qualified = !multiprocEnable || (gotStop && addrMatch); // RULE18 RULE20
    end
    stopMissing = !gotStop;
    rxState_nxt = rxState_r;
    rxCnt_nxt = tick16 ? rxCnt_r + 4'h1 : rxCnt_r;
    rxShift_nxt = rxShift_r;
    sampA_nxt = sampA_r;
    sampB_nxt = sampB_r;
    rxBuf_nxt = rxBuf_r;
    rxNinth_nxt = rxNinth_r;
    rxFull_nxt = rxFull_r;
    frameErr_nxt = frameErr_r;
    modeSelLow_nxt = modeSelLow_r;
    if (rxFullClr) begin
      rxFull_nxt = 1'b0;
    end
    if (ctrlBit7Wr) begin
      if (frameErrSelect) begin
        frameErr_nxt = ctrlBit7WrData; // RULE16 RULE17
      end else begin
        modeSelLow_nxt = ctrlBit7WrData; // RULE16
      end
    end
    case (rxState_r)
      nbu_pkg::RX_HUNT: begin
        if (rxFall && rxEnable && portOn) begin // RULE15
          rxCnt_nxt = 4'h0; // RULE8
          rxShift_nxt = {2'b11, nbu_pkg::RX_LOAD}; // RULE8
          rxState_nxt = nbu_pkg::RX_RECV;
        end
      end
      nbu_pkg::RX_RECV: begin
        if (tick16 && rxCnt_r == nbu_pkg::SAMPLE_FIRST) begin
          sampA_nxt = rxLevel_r; // RULE9
        end
        if (tick16 && rxCnt_r == nbu_pkg::SAMPLE_SECOND) begin
          sampB_nxt = rxLevel_r; // RULE9
        end
        if (tick16 && rxCnt_r == nbu_pkg::SAMPLE_THIRD) begin
          if (rxShift_r == {2'b11, nbu_pkg::RX_LOAD} && majority) begin
            rxState_nxt = nbu_pkg::RX_HUNT; // RULE10
          end else begin
            rxShift_nxt = shifted;
            if (frameDone) begin
              if (!rxFull_r && qualified) begin // RULE11
                rxBuf_nxt = gotData;
                rxNinth_nxt = nineBit ? gotNinth : gotStop; // RULE3
                rxFull_nxt = 1'b1; // RULE25
              end
              if (stopMissing && frameErrSelect) begin
                frameErr_nxt = 1'b1; // RULE16
              end
              rxState_nxt = nbu_pkg::RX_HUNT; // RULE12
            end
          end
        end
        if (!rxEnable || !portOn) begin
          rxState_nxt = nbu_pkg::RX_HUNT;
        end
      end
      default: rxState_nxt = nbu_pkg::RX_HUNT;
    endcase
  end

  // Address registers
  always_comb begin
    slaveAddr_nxt = slaveAddrWr ? addrWrData : slaveAddr_r;
    slaveAddrMask_nxt = slaveAddrMaskWr ? addrWrData : slaveAddrMask_r;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxState_r <= nbu_pkg::RX_HUNT;
      rxCnt_r <= 4'h0;
      rxShift_r <= '1;
      sampA_r <= 1'b1;
      sampB_r <= 1'b1;
      rxBuf_r <= nbu_pkg::DATA_RESET;
      rxNinth_r <= 1'b0;
      rxFull_r <= 1'b0;
      frameErr_r <= 1'b0;
      modeSelLow_r <= 1'b0;
      slaveAddr_r <= nbu_pkg::ADDR_RESET; // RULE23
      slaveAddrMask_r <= nbu_pkg::MASK_RESET; // RULE23
    end else begin
      rxState_r <= rxState_nxt;
      rxCnt_r <= rxCnt_nxt;
      rxShift_r <= rxShift_nxt;
      sampA_r <= sampA_nxt;
      sampB_r <= sampB_nxt;
      rxBuf_r <= rxBuf_nxt;
      rxNinth_r <= rxNinth_nxt;
      rxFull_r <= rxFull_nxt;
      frameErr_r <= frameErr_nxt;
      modeSelLow_r <= modeSelLow_nxt;
      slaveAddr_r <= slaveAddr_nxt;
      slaveAddrMask_r <= slaveAddrMask_nxt;
    end
  end

  // Registered outputs
  logic ctrlBit7_r, irq_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrlBit7_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ctrlBit7_r <= frameErrSelect ? frameErr_nxt : modeSelLow_nxt; // RULE16
      irq_r <= txDone_nxt || rxFull_nxt; // RULE25
    end
  end

  assign ctrlBit7Rd = ctrlBit7_r;
  assign serialIrq = irq_r;
  assign txd = txd_r;
  assign txDoneFlag = txDone_r;
  assign rxFullFlag = rxFull_r;
  assign rxBufData = rxBuf_r;
  assign rxNinthBit = rxNinth_r;
  assign frameErrFlag = frameErr_r;
endmodule : nbu_uart

//--- nbu_uart_bench.sv
// Purpose: Self-checking bench for the nine-bit serial port engine
// Assumes: 20 MHz clock, timer overflow every second clock
// Notes: Remote station model sits on the serial lines
`timescale 1ns/1ps
module nbu_uart_bench;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic txWrValid = 1'b0;
  logic [7:0] txWrData = 8'h00;
  logic modeSelHigh = 1'b1;
  logic multiprocEnable = 1'b0;
  logic rxEnable = 1'b1;
  logic txNinthBit = 1'b0;
  logic rateDouble = 1'b0;
  logic frameErrSelect = 1'b0;
  logic useTimer2 = 1'b0;
  logic ctrlBit7Wr = 1'b0;
  logic ctrlBit7WrData = 1'b0;
  logic txDoneClr = 1'b0;
  logic rxFullClr = 1'b0;
  logic slaveAddrWr = 1'b0;
  logic slaveAddrMaskWr = 1'b0;
  logic [7:0] addrWrData = 8'h00;
  logic tOvf = 1'b0;
  logic txWrReady, ctrlBit7Rd, rxNinthBit, rxFullFlag, txDoneFlag, frameErrFlag, serialIrq;
  logic rxd, txd, refused;
  logic [7:0] rxBufData;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // Rows: {modeSelHigh, ninth, stop, expected flag, data}
  localparam logic [11:0] ROWS [8] = '{12'hD5A, 12'hDC2, 12'hCC4, 12'hDFF, 12'hAC0,
    12'h3C0, 12'h0C0, 12'h2C4};
  always #25 clock = ~clock;
  always @(posedge clock) tOvf <= #1 ~tOvf;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      $display("unexpected at %0t: timeout", $time);
      test_done();
    end
  end
  nbu_uart DUT (.clock(clock), .nrst(nrst), .txWrValid(txWrValid), .txWrData(txWrData),
    .txWrReady(txWrReady), .modeSelHigh(modeSelHigh), .multiprocEnable(multiprocEnable),
    .rxEnable(rxEnable), .txNinthBit(txNinthBit), .rateDouble(rateDouble),
    .frameErrSelect(frameErrSelect), .useTimer2(useTimer2), .ctrlBit7Wr(ctrlBit7Wr),
    .ctrlBit7WrData(ctrlBit7WrData), .ctrlBit7Rd(ctrlBit7Rd), .txDoneClr(txDoneClr),
    .rxFullClr(rxFullClr), .slaveAddrWr(slaveAddrWr), .slaveAddrMaskWr(slaveAddrMaskWr),
    .addrWrData(addrWrData), .t1Overflow(tOvf), .t2Overflow(tOvf), .rxBufData(rxBufData),
    .rxNinthBit(rxNinthBit), .rxFullFlag(rxFullFlag), .txDoneFlag(txDoneFlag),
    .frameErrFlag(frameErrFlag), .serialIrq(serialIrq), .rxd(rxd), .txd(txd));
  nbu_remote rem (.clock(clock), .rxd(rxd), .txd(txd));
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task checkWord(input logic [10:0] got, input logic [10:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask : checkWord
  task checkRange(input int got, input int lo, input int hi, input string msg);
    tests_run++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("unexpected at %0t: %s %0d", $time, msg, got);
    end
  endtask : checkRange
  task pulse(input int which);
    {txDoneClr, rxFullClr, ctrlBit7Wr, slaveAddrWr, slaveAddrMaskWr} = 5'(which);
    step(1);
    {txDoneClr, rxFullClr, ctrlBit7Wr, slaveAddrWr, slaveAddrMaskWr} = 5'h00;
  endtask : pulse
  task writeByte(input logic [7:0] d, input logic nb, input logic last);
    txWrData = d;
    txNinthBit = nb;
    txWrValid = 1'b1;
    while (txWrReady !== 1'b1) begin
      refused = 1'b1;
      step(1);
    end
    step(1);
    if (last) txWrValid = 1'b0;
  endtask : writeByte
  task testTx(input logic rd);
    int n;
    int bl;
    rateDouble = rd;
    bl = rd ? 32 : 64;
    rem.bitLen = bl;
    writeByte(rd ? 8'h5A : 8'hA5, !rd, 1'b1);
    for (n = 0; n < 2000 && txDoneFlag !== 1'b1; n++) step(1);
    checkRange(n, 10 * bl, 11 * bl + 8, "done time");
    step(bl);
    checkRange(rem.frames.size(), 1, 1, "frame count");
    checkWord(rem.frames.pop_front(),
      {2'b11, rd ? 8'h5A : 8'hA5, 1'b0} ^ {1'b0, rd, 9'h0}, "sent frame");
    pulse(16);
    $display("testTx done");
  endtask : testTx
  task testFill;
    int n;
    rateDouble = 1'b1;
    rem.bitLen = 32;
    refused = 1'b0;
    for (int i = 0; i < 5; i++) writeByte(8'(8'h11 * (i + 1)), i[0], i == 4);
    for (n = 0; n < 4000 && rem.frames.size() < 5; n++) step(1);
    checkWord({10'h0, refused}, 11'h001, "buffer never full");
    for (int i = 0; i < 5; i++) checkWord(rem.frames.pop_front(),
      {1'b1, i[0], 8'(8'h11 * (i + 1)), 1'b0}, "queued frame");
    pulse(16);
    $display("testFill done");
  endtask : testFill
  task testRx;
    rateDouble = 1'b0;
    rxEnable = 1'b0;
    rem.sendFrame({2'b10, 8'h3C, 1'b0}, 11, 64);
    checkWord({10'h0, rxFullFlag}, 11'h000, "received while disabled");
    rxEnable = 1'b1;
    rem.sendFrame({2'b10, 8'h3C, 1'b0}, 11, 64);
    checkWord({rxFullFlag, rxNinthBit, serialIrq, rxBufData},
      11'h53C, "rx");
    rem.sendFrame({2'b11, 8'hC3, 1'b0}, 11, 64);
    checkWord({rxFullFlag, rxNinthBit, serialIrq, rxBufData}, 11'h53C, "overrun");
    pulse(8);
    rem.glitch(3);
    step(128);
    checkWord({10'h0, rxFullFlag}, 11'h000, "false start");
    rem.sendFrame({2'b11, 8'h96, 1'b0}, 11, 64);
    checkWord({rxFullFlag, rxNinthBit, serialIrq, rxBufData},
      11'h796, "after glitch");
    pulse(8);
    $display("testRx done");
  endtask : testRx
  task testFrameErr;
    frameErrSelect = 1'b1;
    rem.sendFrame({2'b00, 8'h77, 1'b0}, 11, 64);
    checkWord({frameErrFlag, rxFullFlag, 1'b0, rxBufData}, 11'h677, "bad stop");
    pulse(8);
    step(200);
    checkWord({10'h0, frameErrFlag}, 11'h001, "error kept");
    ctrlBit7WrData = 1'b0;
    pulse(4);
    step(1);
    checkWord({9'h0, frameErrFlag, ctrlBit7Rd}, 11'h000, "error cleared");
    frameErrSelect = 1'b0;
    $display("testFrameErr done");
  endtask : testFrameErr
  task testAddr;
    logic [11:0] r;
    logic [10:0] g, e;
    int n;
    ctrlBit7WrData = 1'b1;
    pulse(4);
    rateDouble = 1'b1;
    multiprocEnable = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = ROWS[i];
      if (i == 1) begin
        addrWrData = 8'hC0;
        pulse(2);
        addrWrData = 8'hFD;
        pulse(1);
      end
      modeSelHigh = r[11];
      useTimer2 = r[11];
      step(2);
      if (r[11]) rem.sendFrame({r[9], r[10], r[7:0], 1'b0}, 11, 32);
      else rem.sendFrame({1'b1, r[9], r[7:0], 1'b0}, 10, 32);
      g = {2'b00, rxFullFlag, r[8] ? rxBufData : 8'h00};
      e = {2'b00, r[8], r[8] ? r[7:0] : 8'h00};
      checkWord(g, e, "addr filter");
      pulse(8);
    end
    // Eight-bit frame carries the stop bit where a ninth bit would be
    writeByte(8'h3B, 1'b0, 1'b1);
    for (n = 0; n < 1000 && txDoneFlag !== 1'b1; n++) step(1);
    checkRange(n, 9 * 32, 10 * 32 + 8, "eight-bit done time");
    step(64);
    checkWord(rem.frames.pop_front(), {2'b11, 8'h3B, 1'b0}, "eight-bit frame");
    pulse(16);
    $display("testAddr done");
  endtask : testAddr
  task test_done;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    step(3);
    nrst = 1'b1;
    step(2);
    checkWord({5'h0, txd, txDoneFlag, rxFullFlag, frameErrFlag, serialIrq, txWrReady}, 11'h021,
      "reset state");
    checkWord({3'h0, rxBufData}, 11'h000, "reset buffer");
    $display("testReset done");
    testTx(1'b0);
    testTx(1'b1);
    testFill();
    testRx();
    testFrameErr();
    testAddr();
    test_done();
  end
endmodule : nbu_uart_bench
bind nbu_uart nbu_chk u_chk (.clock(clock), .nrst(nrst), .txDoneClr(txDoneClr),
  .rxFullClr(rxFullClr), .ctrlBit7Wr(ctrlBit7Wr), .frameErrSelect(frameErrSelect),
  .modeSelHigh(modeSelHigh), .multiprocEnable(multiprocEnable), .rxBufData(rxBufData),
  .rxNinthBit(rxNinthBit), .rxFullFlag(rxFullFlag), .txDoneFlag(txDoneFlag),
  .frameErrFlag(frameErrFlag), .serialIrq(serialIrq), .txd(txd));
